// ==== shared/mmp_pkg.sv ====
// memory map paging constants, address layout and carrier structs
// assumes a 16-bit local address from the core and a 23-bit global address space
package mmp_pkg;

	// ************************************************************
	// address widths
	// ************************************************************
	localparam int LOC_W = 16;
	localparam int GLB_W = 23;

	// ************************************************************
	// local map boundaries
	// ************************************************************
	localparam logic [15:0] LOC_REG_BASE   = 16'h0000;
	localparam logic [15:0] LOC_EE_BASE    = 16'h0800;
	localparam logic [15:0] LOC_EE_FIX     = 16'h0c00;
	localparam logic [15:0] LOC_RAM_BASE   = 16'h1000;
	localparam logic [15:0] LOC_RAM_FIX    = 16'h2000;
	localparam logic [15:0] LOC_FLASH_WIN  = 16'h8000;
	localparam logic [15:0] LOC_FLASH_WEND = 16'hc000;
	localparam logic [15:0] LOC_FLASH_LOW  = 16'h4000;

	// ************************************************************
	// global map regions
	// ************************************************************
	localparam logic [22:0] GLB_EE_BASE    = 23'h10_0000;
	localparam logic [22:0] GLB_EE_END     = 23'h13_ffff;
	localparam logic [22:0] GLB_EE_IMPL    = 23'h13_f000;
	localparam logic [22:0] GLB_RAM_BASE   = 23'h00_1000;
	localparam logic [22:0] GLB_RAM_END    = 23'h0f_ffff;
	localparam logic [22:0] GLB_RAM_IMPL   = 23'h0f_8000;
	localparam logic [22:0] GLB_FLASH_BASE = 23'h40_0000;
	localparam logic [22:0] GLB_FLASH_IMPL = 23'h78_0000;

	// ************************************************************
	// page registers, reset values, fixed pages
	// ************************************************************
	localparam logic [7:0] EE_PAGE_RST    = 8'hfe;
	localparam logic [7:0] EE_PAGE_FIX    = 8'hff;
	localparam logic [7:0] RAM_PAGE_RST   = 8'hfd;
	localparam logic [7:0] RAM_PAGE_FIX0  = 8'hfe;
	localparam logic [7:0] RAM_PAGE_FIX1  = 8'hff;
	localparam logic [7:0] PROG_PAGE_RST  = 8'hfe;
	localparam logic [7:0] PROG_PAGE_LOW  = 8'hfd;
	localparam logic [7:0] PROG_PAGE_HIGH = 8'hff;
	localparam logic [7:0] GLB_PAGE_RST   = 8'h00;
	localparam logic [7:0] DIR_PAGE_RST   = 8'h00;
	localparam logic [4:0] EE_PREFIX      = 5'h04;
	localparam logic [2:0] RAM_PREFIX     = 3'h0;
	localparam logic [0:0] FLASH_PREFIX   = 1'h1;

	// ************************************************************
	// block selects
	// ************************************************************
	typedef enum logic [2:0] {
		BLK_REG   = 3'b000,
		BLK_RAM   = 3'b001,
		BLK_EE    = 3'b010,
		BLK_FLASH = 3'b011,
		BLK_EXT   = 3'b100
	} mmp_blk_type;

	typedef struct packed {
		logic [7:0] global_page_select;
		logic [7:0] eeprom_page_select;
		logic [7:0] ram_page_select;
		logic [7:0] program_page_select;
		logic [7:0] direct_page;
	} mmp_pages_type;

	typedef struct packed {
		logic [22:0] addr;
		mmp_blk_type blk;
		logic        implemented;
	} mmp_map_type;

endpackage : mmp_pkg

// ==== rtl/mmp_mapper.sv ====
// memory map paging: local to global address translation with page registers
// assumes the core presents one access per cycle and holds page writes for one cycle
`timescale 1ns/1ps

// Summary of operation
// RULE1: every local address maps to one fixed place in an 8 Mbyte global space
// RULE2: global accesses take the top 7 bits from global_page_select, low 16 bits from core
// RULE3: registers, RAM, EEPROM, FLASH and external sit at fixed local and global spots
// RULE4: no block relocation; register block always starts at local zero
// RULE5: direct page is 256 bytes, top byte from direct base, low byte from operand
// RULE6: only the first direct base write after reset is accepted
// RULE7: local EEPROM area is 2 Kbyte from 0800 through 0fff
// RULE8: upper EEPROM Kbyte is a fixed page, lower Kbyte windows eeprom_page_select
// RULE9: eeprom_page_select may bring the fixed EEPROM page into the window too
// RULE10: global EEPROM region holds up to 256 Kbytes, implemented part at its top
// RULE11: reference part has 4 Kbytes EEPROM: one fixed page and three pageable
// RULE12: local RAM area is 12 Kbyte from 1000 through 3fff
// RULE13: upper 8 Kbyte RAM fixed from 2000, lower 4 Kbyte windows ram_page_select
// RULE14: ram_page_select may bring either half of fixed RAM into the window
// RULE15: global RAM region holds just under 1 Mbyte, implemented part at its top
// RULE16: reference part has 32 Kbytes RAM: fixed 8 Kbyte plus six 4 Kbyte pages
// RULE17: global FLASH region is upper 4 Mbytes, reached through program page window
// RULE18: paged global address is the page value joined to the window offset bits
module mmp_mapper
	import mmp_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 nrst_i,
	// core access request
	input  wire logic                 acc_valid_i,
	input  wire logic                 acc_global_i,
	input  wire logic                 acc_direct_i,
	input  wire logic [LOC_W-1:0]     acc_addr_i,
	// page register writes
	input  wire logic                 global_page_select_wr_i,
	input  wire logic                 eeprom_page_select_wr_i,
	input  wire logic                 ram_page_select_wr_i,
	input  wire logic                 program_page_select_wr_i,
	input  wire logic                 direct_wr_i,
	input  wire logic [7:0]           page_wdata_i,
	// translated access
	output logic                      map_valid_o,
	output mmp_map_type               map_o,
	// page register state
	output mmp_pages_type             pages_o,
	output logic                      direct_locked_o
);

	// ************************************************************
	// page registers
	// ************************************************************
	mmp_pages_type pages_q;
	logic          direct_locked_q;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pages_q.global_page_select  <= GLB_PAGE_RST;
			pages_q.eeprom_page_select  <= EE_PAGE_RST;
			pages_q.ram_page_select     <= RAM_PAGE_RST;
			pages_q.program_page_select <= PROG_PAGE_RST;
			pages_q.direct_page         <= DIR_PAGE_RST;
			direct_locked_q             <= 1'b0;
		end else begin
			if (global_page_select_wr_i) begin
				pages_q.global_page_select <= page_wdata_i; // RULE2
			end
			if (eeprom_page_select_wr_i) begin
				pages_q.eeprom_page_select <= page_wdata_i; // RULE9
			end
			if (ram_page_select_wr_i) begin
				pages_q.ram_page_select <= page_wdata_i; // RULE14
			end
			if (program_page_select_wr_i) begin
				pages_q.program_page_select <= page_wdata_i;
			end
			// write-once guards against stray code moving the direct page mid-run
			// kept in this process so the page struct has a single driver
			if (direct_wr_i && !direct_locked_q) begin
				pages_q.direct_page <= page_wdata_i; // RULE6
				direct_locked_q     <= 1'b1; // RULE6
			end
		end
	end

	assign pages_o         = pages_q;
	assign direct_locked_o = direct_locked_q;

	// ************************************************************
	// local to global translation
	// ************************************************************
	logic [15:0] laddr;
	mmp_map_type map_d;

	// direct accesses carry only the low byte in acc_addr_i
	assign laddr = acc_direct_i ? {pages_q.direct_page, acc_addr_i[7:0]} : acc_addr_i; // RULE5

	always_comb begin
		map_d.addr        = {7'h00, laddr};
		map_d.blk         = BLK_EXT;
		map_d.implemented = 1'b0;
		if (acc_global_i) begin
			map_d.addr = {pages_q.global_page_select[6:0], acc_addr_i}; // RULE2 RULE1
			if (map_d.addr >= GLB_FLASH_BASE) begin
				map_d.blk         = BLK_FLASH; // RULE17
				map_d.implemented = map_d.addr >= GLB_FLASH_IMPL;
			end else if (map_d.addr >= GLB_EE_BASE && map_d.addr <= GLB_EE_END) begin
				map_d.blk         = BLK_EE; // RULE10
				map_d.implemented = map_d.addr >= GLB_EE_IMPL; // RULE10
			end else if (map_d.addr >= GLB_RAM_BASE && map_d.addr <= GLB_RAM_END) begin
				map_d.blk         = BLK_RAM; // RULE15
				map_d.implemented = map_d.addr >= GLB_RAM_IMPL; // RULE15
			end else if (map_d.addr < GLB_RAM_BASE && map_d.addr < {7'h00, LOC_EE_BASE}) begin
				map_d.blk         = BLK_REG; // RULE3
				map_d.implemented = 1'b1;
			end
		end else if (laddr < LOC_EE_BASE) begin
			map_d.addr        = {7'h00, laddr}; // RULE4
			map_d.blk         = BLK_REG; // RULE4
			map_d.implemented = 1'b1;
		end else if (laddr < LOC_RAM_BASE) begin
			map_d.blk = BLK_EE; // RULE7
			if (laddr >= LOC_EE_FIX) begin
				map_d.addr = {EE_PREFIX, EE_PAGE_FIX, laddr[9:0]}; // RULE8
			end else begin
				map_d.addr = {EE_PREFIX, pages_q.eeprom_page_select, laddr[9:0]}; // RULE8 RULE18
			end
			map_d.implemented = map_d.addr >= GLB_EE_IMPL; // RULE11
		end else if (laddr < LOC_FLASH_LOW) begin
			map_d.blk = BLK_RAM; // RULE12
			if (laddr >= LOC_RAM_FIX) begin
				// fixed 8 Kbyte is the top two 4 Kbyte pages
				map_d.addr = {RAM_PREFIX, laddr[12] ? RAM_PAGE_FIX1 : RAM_PAGE_FIX0,
					laddr[11:0]}; // RULE13
			end else begin
				map_d.addr = {RAM_PREFIX, pages_q.ram_page_select, laddr[11:0]}; // RULE13 RULE18
			end
			map_d.implemented = map_d.addr >= GLB_RAM_IMPL; // RULE16
		end else begin
			map_d.blk = BLK_FLASH; // RULE17
			if (laddr >= LOC_FLASH_WIN && laddr < LOC_FLASH_WEND) begin
				map_d.addr = {FLASH_PREFIX, pages_q.program_page_select[7:0],
					laddr[13:0]}; // RULE17 RULE18
			end else if (laddr < LOC_FLASH_WIN) begin
				map_d.addr = {FLASH_PREFIX, PROG_PAGE_LOW, laddr[13:0]}; // RULE3
			end else begin
				map_d.addr = {FLASH_PREFIX, PROG_PAGE_HIGH, laddr[13:0]}; // RULE3
			end
			map_d.implemented = map_d.addr >= GLB_FLASH_IMPL;
		end
	end

	// ************************************************************
	// registered output
	// ************************************************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			map_valid_o <= 1'b0;
			map_o       <= '0;
		end else begin
			map_valid_o <= acc_valid_i;
			if (acc_valid_i) begin
				map_o <= map_d; // RULE1
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	direct_once_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
		direct_locked_q |=> $stable(pages_q.direct_page))
		else $error("direct page changed after lock");

	direct_first_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
		(direct_wr_i && !direct_locked_q) |=> (pages_q.direct_page == $past(page_wdata_i)))
		else $error("first direct write lost");

	reg_zero_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
		(acc_valid_i && !acc_global_i && !acc_direct_i && acc_addr_i < LOC_EE_BASE)
		|=> (map_o.blk == BLK_REG && map_o.addr[15:0] == $past(acc_addr_i)))
		else $error("register block not at zero");

	glb_page_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE2
		(acc_valid_i && acc_global_i) |=> (map_o.addr[15:0] == $past(acc_addr_i)
		&& map_o.addr[22:16] == $past(pages_q.global_page_select[6:0])))
		else $error("global address not page joined");

	ee_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
		(acc_valid_i && !acc_global_i && !acc_direct_i && acc_addr_i >= LOC_EE_FIX
		&& acc_addr_i < LOC_RAM_BASE) |=> (map_o.blk == BLK_EE && map_o.addr[17:10] == EE_PAGE_FIX))
		else $error("eeprom fixed page wrong");

	ee_window_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE18
		(acc_valid_i && !acc_global_i && !acc_direct_i && acc_addr_i >= LOC_EE_BASE
		&& acc_addr_i < LOC_EE_FIX) |=> (map_o.addr[17:10] == $past(pages_q.eeprom_page_select)))
		else $error("eeprom window page wrong");

	ram_window_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE13
		(acc_valid_i && !acc_global_i && !acc_direct_i && acc_addr_i >= LOC_RAM_BASE
		&& acc_addr_i < LOC_RAM_FIX) |=> (map_o.blk == BLK_RAM
		&& map_o.addr[19:12] == $past(pages_q.ram_page_select)))
		else $error("ram window page wrong");

	ram_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE13
		(acc_valid_i && !acc_global_i && !acc_direct_i && acc_addr_i >= LOC_RAM_FIX
		&& acc_addr_i < LOC_FLASH_LOW) |=> (map_o.addr[22:13] == GLB_RAM_IMPL[22:13] + 10'h3
		&& map_o.addr[12:0] == $past(acc_addr_i[12:0])))
		else $error("ram fixed block wrong");

	direct_page_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE5
		(acc_valid_i && !acc_global_i && acc_direct_i && pages_q.direct_page == 8'h00)
		|=> (map_o.blk == BLK_REG && map_o.addr[7:0] == $past(acc_addr_i[7:0])))
		else $error("direct page address wrong");

	valid_follow_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE1
		acc_valid_i |=> map_valid_o)
		else $error("map valid missing");

	ee_win_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_valid_i && !acc_global_i && acc_addr_i == LOC_EE_BASE);
	ram_win_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_valid_i && !acc_global_i && acc_addr_i == LOC_RAM_BASE);
	glb_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_valid_i && acc_global_i);
	dir_lock_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		direct_wr_i && direct_locked_q);
	flash_win_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_valid_i && !acc_global_i && acc_addr_i == LOC_FLASH_WIN);

	// ************************************************************
	// block and region checks
	// ************************************************************
	// plain local access, neither global nor direct
	logic loc_acc;
	logic glb_acc;

	assign loc_acc = acc_valid_i && !acc_global_i && !acc_direct_i;
	assign glb_acc = acc_valid_i && acc_global_i;

	lock_set_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
		(direct_wr_i && !direct_locked_q) |=> direct_locked_q)
		else $error("direct base not locked");

	ee_block_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE7
		(loc_acc && acc_addr_i >= LOC_EE_BASE && acc_addr_i < LOC_RAM_BASE)
		|=> (map_o.blk == BLK_EE && map_o.addr[22:18] == GLB_EE_BASE[22:18]))
		else $error("eeprom block decode wrong");

	ram_block_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE12
		(loc_acc && acc_addr_i >= LOC_RAM_BASE && acc_addr_i < LOC_FLASH_LOW)
		|=> (map_o.blk == BLK_RAM && map_o.addr[22:20] == GLB_RAM_BASE[22:20]))
		else $error("ram block decode wrong");

	ee_impl_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE11
		(loc_acc && acc_addr_i >= LOC_EE_FIX && acc_addr_i < LOC_RAM_BASE)
		|=> map_o.implemented)
		else $error("fixed eeprom not implemented");

	ram_impl_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE16
		(loc_acc && acc_addr_i >= LOC_RAM_FIX && acc_addr_i < LOC_FLASH_LOW)
		|=> map_o.implemented)
		else $error("fixed ram not implemented");

	ee_swap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE9
		(loc_acc && acc_addr_i >= LOC_EE_BASE && acc_addr_i < LOC_EE_FIX
		&& pages_q.eeprom_page_select == EE_PAGE_FIX) |=> map_o.implemented)
		else $error("fixed eeprom page not in window");

	ram_swap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE14
		(loc_acc && acc_addr_i >= LOC_RAM_BASE && acc_addr_i < LOC_RAM_FIX
		&& (pages_q.ram_page_select == RAM_PAGE_FIX0
		|| pages_q.ram_page_select == RAM_PAGE_FIX1)) |=> map_o.implemented)
		else $error("fixed ram half not in window");

	flash_win_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE17
		(loc_acc && acc_addr_i >= LOC_FLASH_WIN && acc_addr_i < LOC_FLASH_WEND)
		|=> (map_o.blk == BLK_FLASH && map_o.addr[22] == FLASH_PREFIX
		&& map_o.addr[21:14] == $past(pages_q.program_page_select)))
		else $error("flash window page wrong");

	flash_low_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
		(loc_acc && acc_addr_i >= LOC_FLASH_LOW && acc_addr_i < LOC_FLASH_WIN)
		|=> (map_o.blk == BLK_FLASH && map_o.addr[21:14] == PROG_PAGE_LOW))
		else $error("low fixed flash page wrong");

	flash_high_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
		(loc_acc && acc_addr_i >= LOC_FLASH_WEND)
		|=> (map_o.blk == BLK_FLASH && map_o.addr[21:14] == PROG_PAGE_HIGH))
		else $error("high fixed flash page wrong");

	glb_flash_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE17
		(glb_acc && pages_q.global_page_select[6]) |=> map_o.blk == BLK_FLASH)
		else $error("global flash region wrong");

	flash_impl_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE17
		(glb_acc && pages_q.global_page_select[6:0] >= GLB_FLASH_IMPL[22:16])
		|=> map_o.implemented)
		else $error("implemented flash not at top");

	glb_ee_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE10
		(glb_acc && pages_q.global_page_select[6:0] >= GLB_EE_BASE[22:16]
		&& pages_q.global_page_select[6:0] <= GLB_EE_END[22:16]) |=> map_o.blk == BLK_EE)
		else $error("global eeprom region wrong");

	glb_ram_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE15
		(glb_acc && pages_q.global_page_select[6:0] > GLB_RAM_BASE[22:16]
		&& pages_q.global_page_select[6:0] <= GLB_RAM_END[22:16]) |=> map_o.blk == BLK_RAM)
		else $error("global ram region wrong");

	glb_reg_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
		(glb_acc && pages_q.global_page_select[6:0] == GLB_PAGE_RST[6:0]
		&& acc_addr_i < LOC_EE_BASE) |=> map_o.blk == BLK_REG)
		else $error("global register block wrong");

	// the gap below global ram decodes to the external block
	ext_glb_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
		(glb_acc && pages_q.global_page_select[6:0] == GLB_PAGE_RST[6:0]
		&& acc_addr_i >= LOC_EE_BASE && acc_addr_i < LOC_RAM_BASE) |=> map_o.blk == BLK_EXT)
		else $error("global gap not external");

	reg_impl_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
		(loc_acc && acc_addr_i < LOC_EE_BASE) |=> map_o.implemented)
		else $error("register block not implemented");

	// map_o is a data output and must hold between accepted requests
	hold_map_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE1
		!acc_valid_i |=> $stable(map_o))
		else $error("map output moved while idle");

	valid_drop_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE1
		!acc_valid_i |=> !map_valid_o)
		else $error("map valid without request");

endmodule : mmp_mapper

// ==== test/mmp_core_model.sv ====
// core-side partner: issues accesses and page register writes to the mapper
// assumes its tasks are called from one process, each entered at a falling edge
`timescale 1ns/1ps
module mmp_core_model (
	// clock
	input  wire logic        sys_clk_i,
	// requests toward the mapper
	output logic             acc_valid_o,
	output logic             acc_global_o,
	output logic             acc_direct_o,
	output logic [15:0]      acc_addr_o,
	output logic [4:0]       wr_o,
	output logic [7:0]       wdata_o
);
	initial begin
		acc_valid_o = 1'b0;
		acc_global_o = 1'b0;
		acc_direct_o = 1'b0;
		acc_addr_o = 16'h5a5a;
		wr_o = 5'h00;
		wdata_o = 8'ha5;
	end

	// request stands over one rising edge; the caller judges, then calls acc_end
	task automatic acc(input logic g, input logic d, input logic [15:0] a);
		acc_valid_o = 1'b1;
		acc_global_o = g;
		acc_direct_o = d;
		acc_addr_o = a;
		@(negedge sys_clk_i);
	endtask : acc

	// idle qualifiers flip so a stale value can never pass for a held one
	task automatic acc_end();
		acc_valid_o = 1'b0;
		acc_global_o = ~acc_global_o;
		acc_direct_o = ~acc_direct_o;
		acc_addr_o = ~acc_addr_o;
		@(negedge sys_clk_i);
	endtask : acc_end

	// sel: 0 global, 1 eeprom, 2 ram, 3 program, 4 direct base
	task automatic wr(input int sel, input logic [7:0] d);
		wr_o[sel] = 1'b1;
		wdata_o = d;
		@(negedge sys_clk_i);
		wr_o = 5'h00;
		wdata_o = ~d;
		@(negedge sys_clk_i);
	endtask : wr
endmodule : mmp_core_model

// ==== test/memory_map_paging_test.sv ====
// self-checking bench for the memory map paging mapper
// assumes the core model drives every request input at the falling edge
`timescale 1ns/1ps
module memory_map_paging_test;
	import mmp_pkg::*;
	logic          sys_clk_i = 1'b0;
	logic          nrst_i = 1'b0;
	logic          v, g, d;
	logic [15:0]   a;
	logic [4:0]    w;
	logic [7:0]    wd;
	logic          map_valid_o, direct_locked_o;
	mmp_map_type   map_o;
	mmp_pages_type pages_o, exp_p;
	logic          lk;
	int            num_errors = 0;
	int            checked = 0;

	always #2 sys_clk_i = ~sys_clk_i;

	mmp_core_model mmp_core_model_i (.sys_clk_i(sys_clk_i), .acc_valid_o(v),
		.acc_global_o(g), .acc_direct_o(d), .acc_addr_o(a), .wr_o(w), .wdata_o(wd));
	mmp_mapper mmp_mapper_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .acc_valid_i(v),
		.acc_global_i(g), .acc_direct_i(d), .acc_addr_i(a), .global_page_select_wr_i(w[0]),
		.eeprom_page_select_wr_i(w[1]), .ram_page_select_wr_i(w[2]), .program_page_select_wr_i(w[3]), .direct_wr_i(w[4]),
		.page_wdata_i(wd), .map_valid_o(map_valid_o), .map_o(map_o),
		.pages_o(pages_o), .direct_locked_o(direct_locked_o));

	// ************************************************************
	// expectation and compares
	// ************************************************************
	function automatic mmp_map_type exp_map(input logic gl, input logic dr,
		input logic [15:0] la);
		mmp_map_type m;
		logic [22:0] x;
		if (!gl && dr) la = {exp_p.direct_page, la[7:0]};
		if (gl) x = {exp_p.global_page_select[6:0], la};
		else if (la < 16'h0800) x = {7'h00, la};
		else if (la < 16'h0c00) x = {5'h04, exp_p.eeprom_page_select, la[9:0]};
		else if (la < 16'h1000) x = {5'h04, 8'hff, la[9:0]};
		else if (la < 16'h2000) x = {3'h0, exp_p.ram_page_select, la[11:0]};
		else if (la < 16'h4000) x = {10'h07f, la[12:0]};
		else if (la < 16'h8000) x = {1'b1, 8'hfd, la[13:0]};
		else if (la < 16'hc000) x = {1'b1, exp_p.program_page_select, la[13:0]};
		else x = {1'b1, 8'hff, la[13:0]};
		m.addr = x;
		m.implemented = 1'b0;
		if (x >= 23'h40_0000) {m.blk, m.implemented} = {BLK_FLASH, x >= 23'h78_0000};
		else if (x >= 23'h10_0000) {m.blk, m.implemented} = {BLK_EE, x >= 23'h13_f000};
		else if (x >= 23'h00_1000) {m.blk, m.implemented} = {BLK_RAM, x >= 23'h0f_8000};
		else if (x < 23'h00_0800) m.blk = BLK_REG;
		else m.blk = BLK_EXT;
		return m;
	endfunction : exp_map

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk

	// implemented is judged only inside the three memory regions
	task automatic chk_map(input logic gl, input logic dr, input logic [15:0] la);
		mmp_map_type e;
		e = exp_map(gl, dr, la);
		mmp_core_model_i.acc(gl, dr, la);
		checked++;
		if (map_valid_o !== 1'b1 || map_o.addr !== e.addr || map_o.blk !== e.blk ||
			(e.blk inside {BLK_RAM, BLK_EE, BLK_FLASH} && map_o.implemented !== e.implemented)) begin
			num_errors++;
			$display("[ERR] %0t map of %h gave %h expected %h", $time, la, map_o, e);
		end
		mmp_core_model_i.acc_end();
	endtask : chk_map

	task automatic wr(input int sel, input logic [7:0] dv);
		mmp_core_model_i.wr(sel, dv);
		case (sel)
			0: exp_p.global_page_select = dv;
			1: exp_p.eeprom_page_select = dv;
			2: exp_p.ram_page_select = dv;
			3: exp_p.program_page_select = dv;
			default: if (!lk) {exp_p.direct_page, lk} = {dv, 1'b1};
		endcase
	endtask : wr

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_local();
		logic [15:0] t[16] = '{16'h0000, 16'h07ff, 16'h0800, 16'h0bff, 16'h0c00, 16'h0fff,
			16'h1000, 16'h1fff, 16'h2000, 16'h3fff, 16'h4000, 16'h7fff, 16'h8000,
			16'hbfff, 16'hc000, 16'hffff};
		foreach (t[i]) chk_map(1'b0, 1'b0, t[i]);
		@(negedge sys_clk_i);
		chk({39'h0, map_valid_o}, 40'h0);
	endtask : t_local

	task automatic t_paging();
		logic [7:0] ep[4] = '{8'hff, 8'h00, 8'hfc, 8'hfd};
		logic [7:0] rp[5] = '{8'hfe, 8'hff, 8'hf8, 8'hf7, 8'h01};
		logic [7:0] pp[3] = '{8'hfd, 8'he0, 8'h00};
		foreach (ep[i]) begin
			wr(1, ep[i]);
			chk_map(1'b0, 1'b0, 16'h0a55);
		end
		foreach (rp[i]) begin
			wr(2, rp[i]);
			chk_map(1'b0, 1'b0, 16'h1abc);
		end
		foreach (pp[i]) begin
			wr(3, pp[i]);
			chk_map(1'b0, 1'b0, 16'h9123);
		end
	endtask : t_paging

	task automatic t_global();
		logic [23:0] t[8] = '{24'h13f800, 24'h780000, 24'h7fffff, 24'h0f8000,
			24'h000900, 24'h000400, 24'h851234, 24'h100000};
		foreach (t[i]) begin
			wr(0, t[i][23:16]);
			chk_map(1'b1, 1'b0, t[i][15:0]);
		end
		chk_map(1'b1, 1'b1, 16'h0c10);
	endtask : t_global

	task automatic t_direct();
		chk({39'h0, direct_locked_o}, 40'h0);
		chk_map(1'b0, 1'b1, 16'hab45);
		wr(4, 8'h12);
		chk(pages_o, exp_p);
		chk({39'h0, direct_locked_o}, 40'h1);
		wr(4, 8'h34);
		chk(pages_o, exp_p);
		chk_map(1'b0, 1'b1, 16'hab45);
	endtask : t_direct

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim

	initial begin
		#100000;
		num_errors++;
		$display("[ERR] %0t run did not finish in time", $time);
		end_sim();
	end

	initial begin
		exp_p = {GLB_PAGE_RST, EE_PAGE_RST, RAM_PAGE_RST, PROG_PAGE_RST, DIR_PAGE_RST};
		lk = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		nrst_i = 1'b1;
		chk(pages_o, exp_p);
		chk({38'h0, map_valid_o, direct_locked_o}, 40'h0);
		t_local();
		t_paging();
		t_global();
		t_direct();
		end_sim();
	end
endmodule : memory_map_paging_test
